// ===== pkg/adc_ctrl_pkg.sv
// Functional notes
// R01 - reference field 7:5 picks supply, 1.1V, 2.2V, 4.096V or external pin.
// R02 - reference change during a conversion applies only once the conversion completes.
// R03 - bit 2 of the reference and gain register always reads zero.
// R04 - gain field: 00 gain 1, 01 gain 20, 10 gain 100, 11 reserved.
// R05 - adjust clear: right adjusted result, unused high bits read zero.
// R06 - adjust set: left adjusted result, low byte bits 5:0 read zero.
// R07 - reading low byte locks result until high byte is read.
// R08 - adjust bit changes result presentation immediately.
// R09 - enable one powers up; zero powers down and aborts a conversion.
// R10 - first conversion after enable takes 26 converter clocks, others 15.
// R11 - start write begins one conversion; in free running only the first.
// R12 - start bit reads one while converting; writing zero does nothing.
// R13 - auto trigger starts a conversion on rising edge of selected source.
// R14 - done flag sets when a conversion finishes and result is updated.
// R15 - done flag clears on interrupt vector or by writing one.
// R16 - interrupt requested while flag, interrupt enable and global enable are set.
// R17 - prescaler field divides system clock by 2,2,4,8,16,32,64,128.
// R18 - software writes zero to reserved control B bits 7:5.
// R19 - trigger source field 2:0 selects free running or one of seven flags.
// R20 - trigger source has no effect while auto trigger is off.
// R21 - switching to a source whose flag is set counts as rising edge; the code counts it only when the previous source's flag was clear.
// R22 - selecting free running never produces a trigger event.
// R23 - disable bit turns off pin input buffer; port input bit reads zero.
// R24 - channel change during a conversion applies only once it completes.
// R25 - differential results are ten-bit two's complement, 0x200 to 0x1FF.
// R26 - free running with auto trigger restarts on every completion.
// R27 - trigger edge during a conversion is ignored, not queued.
package adc_ctrl_pkg;
    // register indices, byte address is four times the index
    localparam logic [2:0] IDX_REF_GAIN = 3'h1;
    localparam logic [2:0] IDX_CTRL_A   = 3'h2;
    localparam logic [2:0] IDX_CTRL_B   = 3'h3;
    localparam logic [2:0] IDX_DIDR     = 3'h4;
    localparam logic [2:0] IDX_CHANNEL  = 3'h5;
    localparam logic [2:0] IDX_RES_LOW  = 3'h6;
    localparam logic [2:0] IDX_RES_HIGH = 3'h7;
    // control A fields
    localparam int EN_BIT    = 7;
    localparam int START_BIT = 6;
    localparam int ATE_BIT   = 5;
    localparam int FLAG_BIT  = 4;
    localparam int IE_BIT    = 3;
    // control B and reference fields
    localparam int LA_BIT    = 3;
    localparam int REF_LSB   = 5;
    // reference code for the external pin
    localparam logic [2:0] REF_EXT = 3'h4;
    localparam logic [2:0] TS_FREE = 3'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // conversion lengths in converter clocks
    localparam logic [4:0] FIRST_CYCLES  = 5'd26;
    localparam logic [4:0] NORMAL_CYCLES = 5'd15;
    typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
endpackage

// ===== core/adc_control_registers.sv
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module adc_control_registers
#(
    parameter int ADDR_W = 8
)
(
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // converter core
    input  wire logic [9:0]        core_result,
    output logic                   conv_power,
    output logic                   conv_busy,
    output logic                   conv_start,
    output logic                   conv_first,
    output logic      [5:0]        channel_applied,
    output logic      [1:0]        gain_applied,
    output logic      [1:0]        ref_level,
    output logic                   ref_internal_on,
    output logic                   ref_pin_connect,
    // trigger flags and interrupt
    input  wire logic [7:1]        trigger_flags,
    input  wire logic              global_irq_enable,
    input  wire logic              irq_vector_ack,
    output logic                   irq_request,
    // analog pins
    input  wire logic [7:0]        pin_level,
    output logic      [7:0]        pin_digital_input_off,
    output logic      [7:0]        port_input_bit
);
    // the decoder needs five address bits to reach every register
    if (ADDR_W < 5)
    begin : g_addr_check
        $error("ADDR_W must be at least 5");
    end

    logic                      acc_wait;
    logic                      en, ate, flag, ie, la, lock, need_init, trig_prev;
    logic [2:0]                ps, ts, ref_w, ref_a;
    logic [1:0]                gain_w;
    logic [5:0]                mux_w;
    logic [7:0]                didr, pin_s1, pin_s2;
    logic [9:0]                res;
    logic [6:0]                psc;
    logic [4:0]                cnt;
    adc_ctrl_pkg::conv_state_t state;

    // prescaler terminal count: divide by 2 for codes 0 and 1
    function automatic logic [6:0] presc_top(input logic [2:0] sel);
        logic [7:0] div;
        div = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
        return 7'(div - 8'h01);
    endfunction

    // apb decode: aligned word, upper address bits zero
    wire logic [2:0] idx    = paddr[4:2];
    wire logic       mapped = (paddr[1:0] == 2'h0) && ((paddr >> 5) == '0) && (idx != 3'h0);
    wire logic       acc    = psel & penable;
    assign pready  = acc & acc_wait;
    assign pslverr = pready & ~mapped;
    wire logic       wr_ev  = pready & pwrite & mapped;
    wire logic       rd_ev  = pready & ~pwrite & mapped;
    wire logic       wr_a   = wr_ev && (idx == adc_ctrl_pkg::IDX_CTRL_A);

    // one wait state so read data always comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_wait <= 1'b0;
        else
            acc_wait <= acc & ~acc_wait;
    end

    wire logic [7:0] res_lo = la ? {res[1:0], 6'h00} : res[7:0]; // see R05 see R06 see R08
    wire logic [7:0] res_hi = la ? res[9:2] : {6'h00, res[9:8]}; // see R05 see R06 see R08
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        if (!mapped)
            rd_mux = 8'h00;
        else if (idx == adc_ctrl_pkg::IDX_REF_GAIN)
            rd_mux = {ref_w, 3'h0, gain_w}; // see R03
        else if (idx == adc_ctrl_pkg::IDX_CTRL_A)
            rd_mux = {en, conv_busy, ate, flag, ie, ps}; // see R12
        else if (idx == adc_ctrl_pkg::IDX_CTRL_B)
            rd_mux = {4'h0, la, ts};
        else if (idx == adc_ctrl_pkg::IDX_DIDR)
            rd_mux = didr;
        else if (idx == adc_ctrl_pkg::IDX_CHANNEL)
            rd_mux = {2'h0, mux_w};
        else if (idx == adc_ctrl_pkg::IDX_RES_LOW)
            rd_mux = res_lo;
        else
            rd_mux = res_hi;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (acc && !acc_wait && !pwrite)
            prdata <= {24'h000000, rd_mux};
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en     <= 1'b0;
            ate    <= 1'b0;
            ie     <= 1'b0;
            ps     <= 3'h0;
            la     <= 1'b0;
            ts     <= 3'h0;
            ref_w  <= 3'h0;
            gain_w <= 2'h0;
            mux_w  <= 6'h00;
            didr   <= adc_ctrl_pkg::RST_BYTE;
        end
        else if (wr_ev)
        begin
            if (idx == adc_ctrl_pkg::IDX_CTRL_A)
            begin
                en  <= pwdata[adc_ctrl_pkg::EN_BIT]; // see R09
                ate <= pwdata[adc_ctrl_pkg::ATE_BIT];
                ie  <= pwdata[adc_ctrl_pkg::IE_BIT];
                ps  <= pwdata[2:0];
            end
            else if (idx == adc_ctrl_pkg::IDX_CTRL_B)
            begin
                // reserved 7:5 are dropped; software keeps them zero, see R18
                la <= pwdata[adc_ctrl_pkg::LA_BIT];
                ts <= pwdata[2:0]; // see R19
            end
            else if (idx == adc_ctrl_pkg::IDX_REF_GAIN)
            begin
                ref_w  <= pwdata[adc_ctrl_pkg::REF_LSB +: 3];
                gain_w <= pwdata[1:0];
            end
            else if (idx == adc_ctrl_pkg::IDX_CHANNEL)
                mux_w <= pwdata[5:0];
            else if (idx == adc_ctrl_pkg::IDX_DIDR)
                didr <= pwdata[7:0];
        end
    end

    // start sources
    wire logic en_next  = wr_a ? pwdata[adc_ctrl_pkg::EN_BIT] : en;
    wire logic sw_start = wr_a & pwdata[adc_ctrl_pkg::START_BIT] & en_next; // see R11 see R12
    wire logic trig_sig = (ts == adc_ctrl_pkg::TS_FREE) ? 1'b0 : trigger_flags[ts]; // see R22
    // the edge detector follows the selection, so a switch from a clear flag to a set one counts as an edge
    wire logic trig_edge = en & ate & trig_sig & ~trig_prev; // see R13 see R20 see R21
    wire logic tick      = (state == adc_ctrl_pkg::CONV_RUN) && (psc == presc_top(ps));
    wire logic [4:0] target = conv_first ? adc_ctrl_pkg::FIRST_CYCLES
                                         : adc_ctrl_pkg::NORMAL_CYCLES;
    wire logic complete  = tick && (cnt == 5'(target - 5'd1)); // see R10
    wire logic fr_start  = complete & en_next & ate & (ts == adc_ctrl_pkg::TS_FREE); // see R26
    wire logic idle      = (state == adc_ctrl_pkg::CONV_IDLE);
    // edges while running are dropped, there is no pending latch
    wire logic go = en_next & ((idle & (sw_start | trig_edge)) | fr_start); // see R27

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_sig;
    end

    // conversion sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= adc_ctrl_pkg::CONV_IDLE;
        else if (!en_next)
            state <= adc_ctrl_pkg::CONV_IDLE; // see R09
        else
        begin
            case (state)
                adc_ctrl_pkg::CONV_IDLE:
                    if (go)
                        state <= adc_ctrl_pkg::CONV_RUN;
                adc_ctrl_pkg::CONV_RUN:
                    if (complete && !go)
                        state <= adc_ctrl_pkg::CONV_IDLE;
                default:
                    state <= adc_ctrl_pkg::CONV_IDLE;
            endcase
        end
    end

    // prescaler restarts with each conversion so the first period is whole
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psc <= 7'h00;
            cnt <= 5'h00;
        end
        else if (go || idle)
        begin
            psc <= 7'h00;
            cnt <= 5'h00;
        end
        else if (tick)
        begin
            psc <= 7'h00; // see R17
            cnt <= cnt + 5'd1;
        end
        else
            psc <= psc + 7'd1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            need_init  <= 1'b0;
            conv_first <= 1'b0;
            conv_start <= 1'b0;
        end
        else
        begin
            conv_start <= go;
            if (go)
            begin
                conv_first <= need_init | (en_next & ~en); // see R10
                need_init  <= 1'b0;
            end
            else if (en_next && !en)
                need_init <= 1'b1;
        end
    end

    // done flag: a completion in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag <= 1'b0;
        else if (complete)
            flag <= 1'b1; // see R14
        else if (irq_vector_ack || (wr_a && pwdata[adc_ctrl_pkg::FLAG_BIT]))
            flag <= 1'b0; // see R15
    end

    // result kept raw; differential codes stay two's complement, see R25
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res  <= 10'h000;
            lock <= 1'b0;
        end
        else
        begin
            if (complete && !lock)
                res <= core_result; // see R07
            if (rd_ev && idx == adc_ctrl_pkg::IDX_RES_LOW)
                lock <= 1'b1; // see R07
            else if (rd_ev && idx == adc_ctrl_pkg::IDX_RES_HIGH)
                lock <= 1'b0;
        end
    end

    // selections reach the analog side only between conversions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_a           <= 3'h0;
            gain_applied    <= 2'h0;
            channel_applied <= 6'h00;
        end
        else if ((idle && !go) || complete)
        begin
            ref_a           <= ref_w; // see R02
            gain_applied    <= gain_w; // see R04
            channel_applied <= mux_w; // see R24
        end
    end

    // supply and external both give level zero; the pin flag tells them apart
    assign ref_internal_on = (ref_a != adc_ctrl_pkg::REF_EXT) && (ref_a != 3'h0); // see R01
    assign ref_pin_connect = ref_a[2]; // see R01
    assign ref_level       = ref_a[1:0]; // see R01
    assign conv_busy       = ~idle;
    assign conv_power      = en;
    assign irq_request     = flag & ie & global_irq_enable; // see R16

    // pin inputs are asynchronous
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1         <= 8'h00;
            pin_s2         <= 8'h00;
            port_input_bit <= 8'h00;
        end
        else
        begin
            pin_s1         <= pin_level;
            pin_s2         <= pin_s1;
            port_input_bit <= pin_s2 & ~didr; // see R23
        end
    end
    assign pin_digital_input_off = didr; // see R23

    // helper: clocks since start, independent of the sequencer counter
    logic [4:0] chk_ticks;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chk_ticks <= 5'h00;
        else if (conv_start)
            chk_ticks <= 5'h00;
        else if (tick)
            chk_ticks <= chk_ticks + 5'd1;
    end

    AST_FIRST_LEN: assert property (@(posedge pclk) disable iff (!presetn) // see R10
        complete && !conv_start |-> chk_ticks == (conv_first ? 5'd25 : 5'd14))
        else $error("conversion length wrong");
    AST_REF_RES: assert property (@(posedge pclk) disable iff (!presetn) // see R03
        rd_ev && idx == adc_ctrl_pkg::IDX_REF_GAIN |-> prdata[2] == 1'b0)
        else $error("reserved bit read one");
    AST_RIGHT: assert property (@(posedge pclk) disable iff (!presetn) // see R05
        rd_ev && idx == adc_ctrl_pkg::IDX_RES_HIGH && !la |-> prdata[7:2] == 6'h00)
        else $error("right adjust high bits not zero");
    AST_LEFT: assert property (@(posedge pclk) disable iff (!presetn) // see R06
        rd_ev && idx == adc_ctrl_pkg::IDX_RES_LOW && la |-> prdata[5:0] == 6'h00)
        else $error("left adjust low bits not zero");
    AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // see R07
        lock && complete |=> $stable(res))
        else $error("locked result changed");
    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn) // see R09
        wr_a && !pwdata[adc_ctrl_pkg::EN_BIT] |=> !conv_busy ##1 !conv_busy)
        else $error("disable did not abort");
    AST_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // see R14
        complete |=> flag)
        else $error("flag not set on completion");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // see R16
        complete && ie && global_irq_enable |=> irq_request)
        else $error("interrupt not raised");
    AST_HOLD_SEL: assert property (@(posedge pclk) disable iff (!presetn) // see R02 see R24
        conv_busy && !complete |=> $stable(ref_a) && $stable(channel_applied))
        else $error("selection changed mid conversion");
    AST_NO_QUEUE: assert property (@(posedge pclk) disable iff (!presetn) // see R27
        conv_start |-> !$past(conv_busy) || $past(complete))
        else $error("start during a conversion");
    AST_DIDR: assert property (@(posedge pclk) disable iff (!presetn) // see R23
        didr != 8'h00 ##1 $stable(didr) |-> (port_input_bit & didr) == 8'h00)
        else $error("disabled pin reads one");
    AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // see R15
        irq_vector_ack && !complete |=> !flag)
        else $error("flag not cleared by vector");
    AST_START_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // see R12
        wr_a && !pwdata[adc_ctrl_pkg::START_BIT] && !conv_busy && !ate |=> !conv_busy)
        else $error("zero start began a conversion");
    AST_TRIG_START: assert property (@(posedge pclk) disable iff (!presetn) // see R13
        trig_edge && idle && en_next |=> conv_busy)
        else $error("trigger edge did not start");
    AST_FREE_RUN: assert property (@(posedge pclk) disable iff (!presetn) // see R26
        complete && en && ate && ts == adc_ctrl_pkg::TS_FREE && !wr_a |=> conv_busy && conv_start)
        else $error("free running did not restart");
endmodule

// ===== verif/test_adc_control_registers.sv
`timescale 1ns/10ps
module test_adc_control_registers;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  core_result;
    logic        conv_power;
    logic        conv_busy;
    logic        conv_start;
    logic        conv_first;
    logic [5:0]  channel_applied;
    logic [1:0]  gain_applied;
    logic [1:0]  ref_level;
    logic        ref_internal_on;
    logic        ref_pin_connect;
    logic [7:1]  trigger_flags;
    logic        global_irq_enable;
    logic        irq_vector_ack;
    logic        irq_request;
    logic [7:0]  pin_level;
    logic [7:0]  pin_digital_input_off;
    logic [7:0]  port_input_bit;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          num_checks;
    int          n1;
    int          n2;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic e;} row_t;
    row_t        rows [7];

    adc_control_registers adc_control_registers_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_result(core_result), .conv_power(conv_power), .conv_busy(conv_busy),
        .conv_start(conv_start), .conv_first(conv_first), .channel_applied(channel_applied),
        .gain_applied(gain_applied), .ref_level(ref_level), .ref_internal_on(ref_internal_on),
        .ref_pin_connect(ref_pin_connect), .trigger_flags(trigger_flags),
        .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
        .irq_request(irq_request), .pin_level(pin_level),
        .pin_digital_input_off(pin_digital_input_off), .port_input_bit(port_input_bit)
    );

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [7:0] ba(input logic [2:0] i);
        return {3'h0, i, 2'h0};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one idle edge before each setup keeps every signal to one write per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100)
        begin
            fails++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conv(output int n);
        n = 0;
        @(negedge pclk);
        while (conv_busy === 1'b1 && n < 2000)
        begin
            @(negedge pclk);
            n++;
        end
        if (n >= 2000)
        begin
            fails++;
            conclude();
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        conclude();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {core_result, trigger_flags, global_irq_enable, irq_vector_ack} = '0;
        pin_level = 8'hFF;
        rows = '{'{8'h04, 8'hFF, 8'hE3, 1'b0}, '{8'h0C, 8'h0B, 8'h0B, 1'b0},
                 '{8'h10, 8'h5A, 8'h5A, 1'b0}, '{8'h14, 8'h3F, 8'h3F, 1'b0},
                 '{8'h00, 8'h55, 8'h00, 1'b1}, '{8'h20, 8'h55, 8'h00, 1'b1},
                 '{8'h0C, 8'h00, 8'h00, 1'b0}};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 1; i < 8; i++)
        begin
            apb(1'b0, ba(i[2:0]), 8'h00);
            check("reset value", rd, 32'h0);
        end
        $display("reset values done");
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w);
            check("write error", {31'h0, er}, {31'h0, rows[i].e});
            apb(1'b0, rows[i].a, 8'h00);
            check("readback", rd, {24'h0, rows[i].r});
        end
        $display("register rows done");
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, ba(adc_ctrl_pkg::IDX_REF_GAIN), {c[2:0], 3'h0, c[1:0]});
            repeat (2) @(negedge pclk);
            check("ref level", ref_level, (c == 0 || c == 4) ? 2'h0 : c[1:0]);
            check("ref internal", ref_internal_on, c != 0 && c != 4);
            check("ref pin", ref_pin_connect, c[2]);
            check("gain", gain_applied, c[1:0]);
        end
        $display("reference and gain done");
        @(posedge pclk);
        core_result <= 10'h2A5;
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hC0);
        @(negedge pclk);
        check("first flag", conv_first, 1'b1);
        check("start pulse", conv_start, 1'b1);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h00);
        check("start reads one", rd[6], 1'b1);
        check("pulse ends", conv_start, 1'b0);
        conv(n1);
        // 26 clocks at divide by 2, less the four cycles spent on the checks above
        check("first length", n1, 32'd48);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h00);
        check("start and flag", rd[7:4], 4'h9);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_LOW), 8'h00);
        check("right low", rd, 32'hA5);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_HIGH), 8'h00);
        check("right high", rd, 32'h02);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_B), 8'h08);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_HIGH), 8'h00);
        check("left high", rd, 32'hA9);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_LOW), 8'h00);
        check("left low", rd, 32'h40);
        $display("conversion and adjust done");
        core_result <= 10'h155;
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hD0);
        conv(n2);
        check("normal length", n2 >= 29 && n2 <= 32, 1'b1);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_HIGH), 8'h00);
        check("locked high", rd, 32'hA9);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hD3);
        conv(n2);
        check("div8 length", n2 >= 119 && n2 <= 122, 1'b1);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_LOW), 8'h00);
        check("new low", rd, 32'h40);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_RES_HIGH), 8'h00);
        check("new high", rd, 32'h55);
        $display("result lock done");
        global_irq_enable <= 1'b1;
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h88);
        @(negedge pclk);
        check("irq raised", irq_request, 1'b1);
        @(posedge pclk);
        irq_vector_ack <= 1'b1;
        @(posedge pclk);
        irq_vector_ack <= 1'b0;
        @(negedge pclk);
        check("irq acked", irq_request, 1'b0);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hC8);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CHANNEL), 8'h12);
        @(negedge pclk);
        check("channel held", channel_applied, 6'h3F);
        conv(n2);
        check("channel applied", channel_applied, 6'h12);
        check("irq again", irq_request, 1'b1);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h98);
        @(negedge pclk);
        check("irq w1c", irq_request, 1'b0);
        $display("interrupt done");
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hC0);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h00);
        @(negedge pclk);
        check("abort busy", {conv_busy, conv_power}, 2'h0);
        apb(1'b0, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h00);
        check("abort no flag", rd, 32'h0);
        $display("abort done");
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_B), 8'h01);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hA0);
        trigger_flags <= 7'h01;
        repeat (4) @(posedge pclk);
        check("trigger start", conv_busy, 1'b1);
        trigger_flags <= 7'h00;
        @(posedge pclk);
        trigger_flags <= 7'h01;
        conv(n2);
        repeat (4) @(negedge pclk);
        check("edge not queued", conv_busy, 1'b0);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_B), 8'h00);
        repeat (4) @(negedge pclk);
        check("free no trigger", conv_busy, 1'b0);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_B), 8'h01);
        repeat (2) @(negedge pclk);
        check("switch edge", conv_busy, 1'b1);
        conv(n2);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_B), 8'h00);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'hE0);
        repeat (80) @(negedge pclk);
        check("free restart", conv_busy, 1'b1);
        apb(1'b1, ba(adc_ctrl_pkg::IDX_CTRL_A), 8'h00);
        $display("auto trigger done");
        repeat (4) @(negedge pclk);
        check("pin off", pin_digital_input_off, 8'h5A);
        check("port input", port_input_bit, 8'hA5);
        $display("digital input done");
        conclude();
    end
endmodule
